// ---- src/adc_seq_regs.vh ----
`ifndef ADC_SEQ_REGS_VH
`define ADC_SEQ_REGS_VH
// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define IDX_CTL_TWO 8'h02
`define IDX_SEQ_CTL 8'h03
`define IDX_STATUS 8'h06
`define IDX_TEST_ONE 8'h09
`define IDX_RESULT 8'h10
`define IDX_IRQ_STAT 8'h11
`define IDX_IRQ_MASK 8'h12
`define IDX_START 8'h13
// ----------------------------------------
// field positions
// ----------------------------------------
`define CTL2_TRIG_EN 2
`define CTL2_IRQ_EN 1
`define CTL2_IRQ_FLAG 0
`define CTL2_POL 3
`define CTL2_LVL 4
`define SEQ_LEN_HI 6
`define SEQ_LEN_LO 3
`define TEST_SC 0
`define STAT_SCF 7
`define STAT_BUSY 0
// ----------------------------------------
// reset values
// ----------------------------------------
`define SEQ_CTL_RST 8'h20
`define CTL_TWO_RST 8'h00
`define TEST_ONE_RST 8'h00
// ----------------------------------------
// timing
// ----------------------------------------
`define CONV_TIME_NS 2000
`define CLK_PERIOD_NS 100
`define CONV_CYCLES (`CONV_TIME_NS / `CLK_PERIOD_NS)
`endif

// ---- src/adc_sequence_control.v ----
// Summary of operation
// [RULE_01] irq requested only when enable set and sequence-done flag set; here also raised by any irq status bit enabled in the mask
// [RULE_02] irq flag reads complete flag when enabled, else zero; writes ignored
// [RULE_03] trigger sensitivity: 00 fall, 01 rise, 10 low, 11 high
// [RULE_04] writing sequence control aborts running sequence, starts nothing
// [RULE_05] bits 6..3 give sequence length; reset value gives four
// [RULE_06] test bit 0 enables special channel conversions
// [RULE_07] codes 100 high ref, 101 low ref, 110 midpoint, others reserved
// [RULE_08] test bits 7 and 6 read undefined; here they read zero
// [RULE_09] software writes zeros to test bits 7..1 with the enable bit
// [RULE_10] complete flag sets after last conversion result is stored
`timescale 1ns/1ps
`include "adc_seq_regs.vh"
module adc_sequence_control #(
    parameter CONV_CYCLES = `CONV_CYCLES
) (
    input wire clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire trig_pin,
    input wire [2:0] chan_code,
    input wire [9:0] conv_data,
    output reg [3:0] mux_sel,
    output reg conv_busy,
    output reg irq
);
    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg [7:0] ctl_two_q;
    reg [7:0] seq_ctl_q;
    reg [7:0] test_one_q;
    reg scf_q;
    reg [9:0] result_q;
    reg [1:0] irq_stat_q;
    reg [1:0] irq_mask_q;
    reg active_q;
    reg [3:0] done_cnt_q;
    reg [15:0] tick_q;
    wire trig_fire;
    wire [3:0] sel_w;
    wire sel_reserved;
    wire [9:0] idx;
    wire wr_en;
    wire rd_en;
    wire irq_flag;
    wire [3:0] seq_len;
    wire conv_done;
    wire start_req;
    wire seq_end;
    assign idx = paddr[11:2];
    assign wr_en = psel & penable & pwrite & pready;
    assign rd_en = psel & ~penable & ~pwrite;
    assign irq_flag = ctl_two_q[`CTL2_IRQ_EN] & scf_q; // RULE_02
    assign seq_len = seq_ctl_q[`SEQ_LEN_HI:`SEQ_LEN_LO]; // RULE_05
    assign conv_done = active_q && (tick_q == CONV_CYCLES[15:0] - 16'h0001);
    // a zero length field runs eight conversions, avoiding an endless sequence
    assign seq_end = conv_done &&
        (done_cnt_q + 4'h1 == ((seq_len == 4'h0) ? 4'h8 : seq_len));
    assign start_req = (wr_en && idx == `IDX_START && pwdata[0]) ||
        (ctl_two_q[`CTL2_TRIG_EN] && trig_fire);
    trig_detect u_trig (
        .clk(clk),
        .rst(rst),
        .trig_pin(trig_pin),
        .trigger_level_select(ctl_two_q[`CTL2_LVL]),
        .trigger_polarity(ctl_two_q[`CTL2_POL]),
        .fire(trig_fire)
    );
    chan_select u_sel (
        .code(chan_code),
        .special_channel_enable(test_one_q[`TEST_SC]),
        .mux_sel(sel_w),
        .reserved(sel_reserved)
    );
    // ----------------------------------------
    // apb slave, one wait-free access phase
    // ----------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel & ~penable;
            pslverr <= 1'b0;
            if (psel & ~penable) begin
                case (idx)
                    `IDX_CTL_TWO, `IDX_SEQ_CTL, `IDX_STATUS, `IDX_TEST_ONE,
                    `IDX_RESULT, `IDX_IRQ_STAT, `IDX_IRQ_MASK, `IDX_START:
                        pslverr <= 1'b0;
                    default: pslverr <= 1'b1;
                endcase
            end
            if (rd_en) begin
                case (idx)
                    `IDX_CTL_TWO: prdata <= {24'h0, ctl_two_q[7:1], irq_flag}; // RULE_02
                    `IDX_SEQ_CTL: prdata <= {24'h0, seq_ctl_q};
                    `IDX_STATUS: prdata <= {24'h0, scf_q, 6'h00, active_q};
                    // upper test bits return zero, a legal reading of undefined
                    `IDX_TEST_ONE: prdata <= {24'h0, 2'b00, test_one_q[5:0]}; // RULE_08
                    `IDX_RESULT: prdata <= {22'h0, result_q};
                    `IDX_IRQ_STAT: prdata <= {30'h0, irq_stat_q};
                    `IDX_IRQ_MASK: prdata <= {30'h0, irq_mask_q};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end
    // ----------------------------------------
    // control registers
    // ----------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            ctl_two_q <= `CTL_TWO_RST;
            seq_ctl_q <= `SEQ_CTL_RST; // RULE_05
            test_one_q <= `TEST_ONE_RST;
            irq_mask_q <= 2'b00;
        end else if (wr_en) begin
            case (idx)
                // flag bit is not stored; writes to it are dropped
                `IDX_CTL_TWO: ctl_two_q <= {pwdata[7:1], 1'b0}; // RULE_02
                `IDX_SEQ_CTL: seq_ctl_q <= pwdata[7:0];
                // upper bits stored as written; software keeps them zero
                `IDX_TEST_ONE: test_one_q <= pwdata[7:0]; // RULE_09
                `IDX_IRQ_MASK: irq_mask_q <= pwdata[1:0];
                default: ctl_two_q <= ctl_two_q;
            endcase
        end
    end
    // ----------------------------------------
    // sequence engine
    // ----------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            active_q <= 1'b0;
            done_cnt_q <= 4'h0;
            tick_q <= 16'h0000;
            scf_q <= 1'b0;
            result_q <= 10'h000;
        end else begin
            if (wr_en && idx == `IDX_SEQ_CTL) begin
                active_q <= 1'b0; // RULE_04
                done_cnt_q <= 4'h0;
                tick_q <= 16'h0000;
            end else if (start_req && !active_q) begin
                active_q <= 1'b1;
                done_cnt_q <= 4'h0;
                tick_q <= 16'h0000;
                scf_q <= 1'b0;
            end else if (active_q) begin
                if (conv_done) begin
                    tick_q <= 16'h0000;
                    result_q <= sel_reserved ? 10'h000 : conv_data;
                    done_cnt_q <= done_cnt_q + 4'h1;
                    if (seq_end) begin
                        active_q <= 1'b0;
                        scf_q <= 1'b1; // RULE_10
                    end
                end else begin
                    tick_q <= tick_q + 16'h0001;
                end
            end
        end
    end
    // ----------------------------------------
    // interrupt status: bit0 sequence done, bit1 abort
    // ----------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            irq_stat_q <= 2'b00;
        end else begin
            irq_stat_q[0] <= (active_q & seq_end) |
                (irq_stat_q[0] & ~(wr_en && idx == `IDX_IRQ_STAT && pwdata[0]));
            irq_stat_q[1] <= (active_q & wr_en & (idx == `IDX_SEQ_CTL)) |
                (irq_stat_q[1] & ~(wr_en && idx == `IDX_IRQ_STAT && pwdata[1]));
        end
    end
    always @(posedge clk) begin
        if (rst) begin
            irq <= 1'b0;
            mux_sel <= 4'h0;
            conv_busy <= 1'b0;
        end else begin
            irq <= irq_flag | (|(irq_stat_q & irq_mask_q)); // RULE_01
            mux_sel <= sel_w;
            conv_busy <= active_q;
        end
    end
endmodule

// ---- src/chan_select.v ----
`timescale 1ns/1ps
module chan_select (
    input wire [2:0] code,
    input wire special_channel_enable,
    output reg [3:0] mux_sel,
    output reg reserved
);
    // mux_sel: 0..7 analog pins, 8 ref_high, 9 ref_low, 10 midpoint
    always @* begin
        reserved = 1'b0;
        mux_sel = {1'b0, code};
        if (special_channel_enable) begin // RULE_06
            case (code) // RULE_07
                3'b100: mux_sel = 4'h8;
                3'b101: mux_sel = 4'h9;
                3'b110: mux_sel = 4'hA;
                default: begin
                    mux_sel = 4'hF;
                    reserved = 1'b1;
                end
            endcase
        end
    end
endmodule

// ---- src/trig_detect.v ----
`timescale 1ns/1ps
module trig_detect (
    input wire clk,
    input wire rst,
    input wire trig_pin,
    input wire trigger_level_select,
    input wire trigger_polarity,
    output reg fire
);
    reg s1_q;
    reg s2_q;
    reg prev_q;
    always @(posedge clk) begin
        if (rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            s1_q <= trig_pin;
            s2_q <= s1_q;
            prev_q <= s2_q;
        end
    end
    always @* begin
        case ({trigger_level_select, trigger_polarity}) // RULE_03
            2'b00: fire = prev_q & ~s2_q;
            2'b01: fire = ~prev_q & s2_q;
            2'b10: fire = ~s2_q;
            default: fire = s2_q;
        endcase
    end
endmodule

// ---- test/adc_seq_check_sva.sv ----
`timescale 1ns/1ps
`include "adc_seq_regs.vh"
module adc_seq_check #(parameter CONV_CYCLES = 4) (
    input wire clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [3:0] mux_sel,
    input wire conv_busy,
    input wire irq
);
default clocking @(posedge clk); endclocking
default disable iff (rst);
sequence s_setup;
    psel && !penable;
endsequence
sequence s_rd(idx);
    pready && !pwrite && paddr == {2'b00, idx, 2'b00};
endsequence
sequence s_seq_wr;
    pready && pwrite && paddr == {2'b00, `IDX_SEQ_CTL, 2'b00};
endsequence
a_ready_after_setup: assert property (s_setup |=> pready && penable)
    else $error("late ready");
a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("long ready");
a_err_reads_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("bad error reply");
a_reset_quiet: assert property ($past(rst) |-> !irq && !conv_busy && !pready)
    else $error("active after reset");
a_write_aborts: assert property (s_seq_wr |-> ##[1:3] !conv_busy)
    else $error("no abort");
a_mux_legal: assert property (!(mux_sel inside {[4'hB:4'hE]}))
    else $error("bad mux code");
a_test_top_zero: assert property (s_rd(`IDX_TEST_ONE) |-> prdata[7:6] == 2'b00)
    else $error("test top bits");
a_flag_masked: assert property (s_rd(`IDX_CTL_TWO) ##0 !prdata[1] |-> !prdata[0])
    else $error("flag not masked");
a_irq_on_flag: assert property (s_rd(`IDX_CTL_TWO) ##0 prdata[1:0] == 2'b11 |-> ##[0:2] irq)
    else $error("no irq");
endmodule

// ---- test/adc_sequence_control_bench.sv ----
`timescale 1ns/1ps
`include "adc_seq_regs.vh"
module adc_sequence_control_bench;
localparam CONV_CYCLES = 4;
reg clk = 0;
reg rst = 1;
reg psel = 0;
reg penable = 0;
reg pwrite = 0;
reg [11:0] paddr = 0;
reg [31:0] pwdata = 0;
reg [2:0] chan_code = 0;
reg [31:0] rd;
reg err;
reg [3:0] exp;
integer fails = 0;
integer checks = 0;
integer i, n2, n4;
wire [31:0] prdata;
wire [3:0] mux_sel;
wire [9:0] conv_data;
wire pready, pslverr, trig_pin, conv_busy, irq;
always #50 clk = ~clk;
adc_sequence_control #(.CONV_CYCLES(CONV_CYCLES)) adc_sequence_control_inst (.clk(clk),
    .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .trig_pin(trig_pin),
    .chan_code(chan_code), .conv_data(conv_data), .mux_sel(mux_sel), .conv_busy(conv_busy),
    .irq(irq));
analog_front analog_front_inst (.clk(clk), .mux_sel(mux_sel), .conv_data(conv_data),
    .trig_pin(trig_pin));
// ----
// tasks
// ----
task close_out;
    begin
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
endtask
task check(input [31:0] seen, input [31:0] want, input [47:0] what);
    begin
        checks = checks + 1;
        if (seen !== want) begin
            fails = fails + 1;
            $display("[FAIL] %0s expected %h seen %h", what, want, seen);
        end
    end
endtask
// idle cycle before each setup so psel never gets two writes in one step
task apb(input wr, input [7:0] idx, input [31:0] wd);
    integer n;
    begin
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20) begin
            n = n + 1;
            @(posedge clk);
        end
        if (n == 20) begin
            fails = fails + 1;
            close_out;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    end
endtask
task wait_busy(input v, output integer n);
    begin
        n = 0;
        while (conv_busy !== v && n < 300) begin
            n = n + 1;
            @(posedge clk);
        end
        if (n == 300) begin
            fails = fails + 1;
            close_out;
        end
    end
endtask
task run_seq(output integer n);
    begin
        apb(1, `IDX_START, 32'h1);
        wait_busy(1, n);
        wait_busy(0, n);
    end
endtask
// ----
// scenarios
// ----
task t_regs;
    begin
        apb(0, `IDX_SEQ_CTL, 0);
        check(rd, 32'h20, "seqrst");
        apb(0, `IDX_TEST_ONE, 0);
        check(rd, 32'h0, "test");
        apb(0, 8'hFF, 0);
        check({rd[30:0], err}, 32'h1, "unmap");
    end
endtask
task t_chan;
    begin
        apb(1, `IDX_TEST_ONE, 32'h1);
        for (i = 0; i < 9; i = i + 1) begin
            if (i == 8)
                apb(1, `IDX_TEST_ONE, 32'h0);
            chan_code <= (i == 8) ? 3'h4 : i[2:0];
            exp = (i == 8) ? 4'h4 : (i == 4) ? 4'h8 : (i == 5) ? 4'h9 : (i == 6) ? 4'hA : 4'hF;
            apb(1, `IDX_START, 32'h1);
            wait_busy(1, n2);
            @(posedge clk);
            check(mux_sel, exp, "mux");
            wait_busy(0, n2);
            apb(0, `IDX_RESULT, 0);
            check(rd, (exp == 4'hF) ? 32'h0 : (exp == 4'h8) ? 32'h3FF : {22'h0, 6'h15, exp}, "result");
        end
    end
endtask
task t_seq;
    begin
        check(irq, 0, "irqmsk");
        apb(1, `IDX_IRQ_MASK, 32'h1);
        run_seq(n4);
        apb(1, `IDX_SEQ_CTL, 32'h10);
        run_seq(n2);
        check(n4 - n2, 2 * CONV_CYCLES, "seqlen");
        apb(0, `IDX_STATUS, 0);
        check(rd[7], 1, "done");
        check(irq, 1, "irqst");
        apb(1, `IDX_IRQ_STAT, 32'h1);
        apb(1, `IDX_CTL_TWO, 32'h1);
        apb(0, `IDX_CTL_TWO, 0);
        check(rd[1:0], 0, "flagof");
        check(irq, 0, "irqof");
        apb(1, `IDX_CTL_TWO, 32'h2);
        apb(0, `IDX_CTL_TWO, 0);
        check(rd[1:0], 3, "flagon");
        check(irq, 1, "irqon");
        apb(1, `IDX_CTL_TWO, 32'h0);
        apb(1, `IDX_IRQ_MASK, 32'h0);
    end
endtask
task t_abort;
    begin
        apb(1, `IDX_SEQ_CTL, 32'h0);
        apb(1, `IDX_IRQ_STAT, 32'h3);
        apb(1, `IDX_START, 32'h1);
        wait_busy(1, n2);
        apb(1, `IDX_SEQ_CTL, 32'h20);
        repeat (20) @(posedge clk);
        check(conv_busy, 0, "abort");
        apb(0, `IDX_IRQ_STAT, 0);
        check(rd[1:0], 2, "abflag");
    end
endtask
task t_trig;
    begin
        for (i = 0; i < 4; i = i + 1) begin
            analog_front_inst.set_trig(~i[0]);
            apb(1, `IDX_CTL_TWO, {27'h0, i[1:0], 3'h4});
            repeat (8) @(posedge clk);
            check(conv_busy, 0, "trigq");
            analog_front_inst.set_trig(i[0]);
            wait_busy(1, n2);
            analog_front_inst.set_trig(~i[0]);
            apb(1, `IDX_CTL_TWO, 32'h0);
            apb(1, `IDX_SEQ_CTL, 32'h20);
            wait_busy(0, n2);
        end
    end
endtask
initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_chan;
    t_seq;
    t_abort;
    t_trig;
    close_out;
end
endmodule
bind adc_sequence_control adc_seq_check #(.CONV_CYCLES(CONV_CYCLES)) adc_seq_check_inst (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .mux_sel(mux_sel),
    .conv_busy(conv_busy), .irq(irq));

// ---- test/analog_front.sv ----
`timescale 1ns/1ps
module analog_front (
    input wire clk,
    input wire [3:0] mux_sel,
    output reg [9:0] conv_data,
    output reg trig_pin
);
// each input gives its own sample, so a wrong mux choice shows up
always @* begin
    conv_data = {6'h15, mux_sel};
    if (mux_sel == 4'h8)
        conv_data = 10'h3FF;
end
initial trig_pin = 1'b0;
task set_trig(input v);
    begin
        @(posedge clk);
        trig_pin <= v;
    end
endtask
endmodule
